// ### cpu_pkg.sv
// Purpose: shared constants for the small cpu core
// Assumes: 8-bit data, 16-bit address, one memory access per cycle
// Notes:   opcodes follow the instruction set encoding
package cpu_pkg;
  // ********************
  // opcodes
  // ********************
  localparam logic [7:0] OP_INDEX_PLUS_B   = 8'h3a;
  localparam logic [7:0] OP_MUL            = 8'h3d;
  localparam logic [7:0] OP_PUSH_INDEX     = 8'h3c;
  localparam logic [7:0] OP_POP_INDEX      = 8'h38;
  localparam logic [7:0] OP_BRANCH_NEVER   = 8'h21;
  localparam logic [7:0] OP_BRANCH_ALWAYS  = 8'h20;
  localparam logic [7:0] OP_SHL_DOUBLE     = 8'h05;
  localparam logic [7:0] OP_SHR_DOUBLE     = 8'h04;
  localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h19;
  localparam logic [7:0] OP_NOP            = 8'h01;
  // ********************
  // reset values and counts
  // ********************
  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [15:0] SP_RESET  = 16'h00ff;
  localparam logic [15:0] X_RESET   = 16'h0000;
  localparam logic [5:0]  CC_RESET  = 6'h10;
  localparam logic [3:0]  MUL_CYCLES = 4'ha;
  localparam logic [3:0]  BRN_CYCLES = 4'h3;
  // address modes, decoded from opcode bits 5:4 for the 0x80..0xff rows
  typedef enum logic [2:0] {
    MODE_IMPLIED  = 3'h0,
    MODE_RELATIVE = 3'h1,
    MODE_IMMED    = 3'h2,
    MODE_DIRECT   = 3'h3,
    MODE_INDEXED  = 3'h4,
    MODE_EXTENDED = 3'h5
  } addr_mode_t;
  // ********************
  // shared helpers
  // ********************
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    add16 = a + b;
  endfunction
endpackage

// ### ea_unit.sv
// Purpose: effective address generation
// Assumes: operand bytes already fetched
// Notes:   purely combinational
`timescale 1ns/100ps
module ea_unit (
  // mode and operands
  input  wire cpu_pkg::addr_mode_t mode,
  input  wire logic [7:0]          byte2,
  input  wire logic [7:0]          byte3,
  input  wire logic [15:0]         index,
  input  wire logic [15:0]         pc_op,
  // result
  output logic [15:0]              ea
);
  import cpu_pkg::*;
  logic [8:0]  lo_sum;
  logic [15:0] rel_target;
  // indexed low byte with carry into high byte
  assign lo_sum     = {1'b0, index[7:0]} + {1'b0, byte2};
  assign rel_target = add16(pc_op + 16'h0002, {{8{byte2[7]}}, byte2});
  // mode select
  always_comb begin
    case (mode)
      // RQ1: zero page
      MODE_DIRECT:   ea = {8'h00, byte2};
      // RQ2: high then low
      MODE_EXTENDED: ea = {byte2, byte3};
      // RQ3: RQ4: unsigned offset plus carry
      MODE_INDEXED:  ea = {index[15:8] + {7'h00, lo_sum[8]}, lo_sum[7:0]};
      // RQ6: signed offset from pc plus two
      MODE_RELATIVE: ea = rel_target;
      default:       ea = 16'h0000;
    endcase
  end
endmodule

// ### alu16.sv
// Purpose: 16-bit arithmetic for the double operations
// Assumes: operands stable for the execute cycle
// Notes:   flags returned as n,z,v,c
`timescale 1ns/100ps
module alu16 (
  // operands
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic        sub,
  // result
  output logic [15:0]      y,
  output logic [3:0]       nzvc
);
  logic [16:0] full;
  logic        ovf;
  // add or subtract with carry/borrow out
  assign full = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
  assign y    = full[15:0];
  assign ovf  = sub ? ((a[15] ^ b[15]) & (a[15] ^ y[15])) : (~(a[15] ^ b[15]) & (a[15] ^ y[15]));
  assign nzvc = {y[15], y == 16'h0000, ovf, full[16]};
endmodule

// ### cpu_core.sv
// Purpose: cpu core fetch, address generation and the 16-bit instructions
// Assumes: memory answers a read in the same cycle (combinational rdata)
// Notes:   only the listed subset is executed; other opcodes act as nop
// How it works
// RQ1: direct mode uses byte two as zero-page address, two bytes long.
// RQ2: extended mode forms address from byte two high, byte three low.
// RQ3: indexed mode adds unsigned byte two to index low byte.
// RQ4: carry from indexed low add goes into index high byte.
// RQ5: indexed address held in temporary register, index unchanged.
// RQ6: relative target is pc plus two plus signed byte two.
// RQ7: implied instructions are one byte, operand implied by opcode.
// RQ8: index_plus_b adds unsigned b into index, flags untouched.
// RQ9: sum_double_accum adds memory word into double accumulator.
// RQ10: subtract_double subtracts memory word from double accumulator.
// RQ11: shift_left_double shifts left, zero in, old msb to carry.
// RQ12: shift_right_double shifts right, zero in, old lsb to carry.
// RQ13: load_double loads a then b, sets n z, clears v.
// RQ14: store_double writes a to m and b to m+1.
// RQ15: multiply a by b unsigned, high to a, low to b, ten cycles.
// RQ16: push_index stores low, decrements, stores high, decrements.
// RQ17: pop_index increments, loads high, increments, loads low.
// RQ18: branch_never never branches, two bytes, three cycles.
// RQ19: compare_index subtracts memory word from index, sets n z v c.
// RQ20: decimal_adjust corrects a to bcd after addition, updates carry.
// RQ21: double accumulator is a high, b low.
// RQ22: after multiply carry equals bit 7 of b.
// RQ23: fetch opcode and operands from successive addresses, advancing pc.
`timescale 1ns/100ps
module cpu_core (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // memory bus
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // visible state
  output logic [7:0]       acc_a,
  output logic [7:0]       acc_b,
  output logic [15:0]      index_reg,
  output logic [15:0]      stack_ptr,
  output logic [15:0]      prog_ctr,
  output logic [5:0]       cond_codes,
  output logic             instr_done
);
  import cpu_pkg::*;

  // ********************
  // state machine
  // ********************
  typedef enum logic [2:0] {
    S_FETCH = 3'b000,
    S_OP1   = 3'b001,
    S_OP2   = 3'b011,
    S_EXEC  = 3'b010,
    S_MEM1  = 3'b110,
    S_MEM2  = 3'b111,
    S_WAIT  = 3'b101
  } state_t;

  state_t      st_q, st_d;
  logic [7:0]  a_q, b_q, op_q, b2_q, b3_q, hi_q;
  logic [15:0] x_q, sp_q, pc_q, tmp_q;
  logic [5:0]  cc_q;            // h i n z v c
  logic [3:0]  wait_q;

  // ********************
  // decode
  // ********************
  addr_mode_t  mode;
  logic        is_word_op, is_ldd, is_std, is_sum_double_accum, is_subtract_double, is_cpx;
  logic [1:0]  nbytes;
  logic [15:0] ea;
  // mode from the opcode row
  assign mode = (op_q[7:4] == 4'h2) ? MODE_RELATIVE :
                (op_q[7:6] == 2'b00 || op_q[7:6] == 2'b01) ? MODE_IMPLIED :
                (op_q[5:4] == 2'b00) ? MODE_IMMED :
                (op_q[5:4] == 2'b01) ? MODE_DIRECT :
                (op_q[5:4] == 2'b10) ? MODE_INDEXED : MODE_EXTENDED;
  assign is_ldd  = op_q[7:6] == 2'b11 && op_q[3:0] == 4'hc;
  assign is_std  = op_q[7:6] == 2'b11 && op_q[3:0] == 4'hd && op_q[5:4] != 2'b00;
  assign is_sum_double_accum = op_q[7:6] == 2'b11 && op_q[3:0] == 4'h3;
  assign is_subtract_double = op_q[7:6] == 2'b10 && op_q[3:0] == 4'h3;
  assign is_cpx  = op_q[7:6] == 2'b10 && op_q[3:0] == 4'hc;
  assign is_word_op = is_ldd | is_std | is_sum_double_accum | is_subtract_double | is_cpx;
  // RQ1: RQ2: RQ3: RQ6: RQ7: instruction length by mode
  assign nbytes = (mode == MODE_IMPLIED) ? 2'd1 :
                  (mode == MODE_EXTENDED || (mode == MODE_IMMED && is_word_op)) ? 2'd3 : 2'd2;

  ea_unit u_ea (
    .mode  (mode),
    .byte2 (b2_q),
    .byte3 (b3_q),
    .index (x_q),
    .pc_op (pc_q - 16'h0002),
    .ea    (ea)
  );

  // ********************
  // arithmetic
  // ********************
  logic [15:0] dbl, opnd, alu_y, prod, index_plus_b;
  logic [3:0]  alu_f;
  logic [7:0]  daa_fix, daa_a;
  logic        daa_c;
  // RQ21: a is the high byte
  assign dbl  = {a_q, b_q};
  // immediate words come from the two operand bytes, the bus is idle in execute
  assign opnd = (mode == MODE_IMMED) ? {b2_q, b3_q} : {hi_q, mem_rdata};
  alu16 u_alu (
    .a    (is_cpx ? x_q : dbl),
    .b    (opnd),
    .sub  (is_subtract_double | is_cpx),
    .y    (alu_y),
    .nzvc (alu_f)
  );
  // RQ15: unsigned product
  assign prod = {8'h00, a_q} * {8'h00, b_q};
  // RQ8: unsigned b, carry into high byte
  assign index_plus_b  = add16(x_q, {8'h00, b_q});
  // RQ20: bcd correction from half carry and carry
  assign daa_fix = {(cc_q[0] || a_q[7:4] > 4'h9 || (a_q[7:4] > 4'h8 && a_q[3:0] > 4'h9)) ? 4'h6 : 4'h0,
                    (cc_q[5] || a_q[3:0] > 4'h9) ? 4'h6 : 4'h0};
  assign daa_a   = a_q + daa_fix;
  assign daa_c   = cc_q[0] | (daa_fix[7:4] != 4'h0);

  // ********************
  // bus drive and next state
  // ********************
  logic operand_mem;
  assign operand_mem = is_word_op && mode != MODE_IMMED;
  always_comb begin
    st_d      = st_q;
    mem_addr  = pc_q;
    mem_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_wdata = 8'h00;
    case (st_q)
      // RQ23: each byte from the next pc
      S_FETCH: begin
        mem_rd = 1'b1;
        st_d   = S_OP1;
      end
      S_OP1: begin
        mem_rd = nbytes != 2'd1;
        st_d   = (nbytes == 2'd3) ? S_OP2 : S_EXEC;
      end
      S_OP2: begin
        mem_rd = 1'b1;
        st_d   = S_EXEC;
      end
      S_EXEC: begin
        if (op_q == OP_PUSH_INDEX || op_q == OP_POP_INDEX || operand_mem) begin
          st_d = S_MEM1;
        end else if (op_q == OP_MUL) begin
          // RQ15: only multiply stalls; branch_never ends here in three cycles (RQ18)
          st_d = S_WAIT;
        end else begin
          st_d = S_FETCH;
        end
      end
      S_MEM1: begin
        // RQ16: low byte at sp first
        if (op_q == OP_PUSH_INDEX) begin
          mem_addr  = sp_q;
          mem_wr    = 1'b1;
          mem_wdata = x_q[7:0];
        end else if (op_q == OP_POP_INDEX) begin
          mem_addr = sp_q + 16'h0001;
          mem_rd   = 1'b1;
        end else if (is_std) begin
          mem_addr  = tmp_q;
          mem_wr    = 1'b1;
          mem_wdata = a_q;
        end else begin
          mem_addr = tmp_q;
          mem_rd   = 1'b1;
        end
        st_d = S_MEM2;
      end
      S_MEM2: begin
        // RQ14: b goes to m+1
        if (op_q == OP_PUSH_INDEX) begin
          mem_addr  = sp_q;
          mem_wr    = 1'b1;
          mem_wdata = x_q[15:8];
        end else if (op_q == OP_POP_INDEX) begin
          mem_addr = sp_q + 16'h0001;
          mem_rd   = 1'b1;
        end else if (is_std) begin
          mem_addr  = tmp_q + 16'h0001;
          mem_wr    = 1'b1;
          mem_wdata = b_q;
        end else begin
          mem_addr = tmp_q + 16'h0001;
          mem_rd   = 1'b1;
        end
        st_d = S_FETCH;
      end
      S_WAIT: begin
        if (wait_q == 4'h0) begin
          st_d = S_FETCH;
        end
      end
      default: st_d = S_FETCH;
    endcase
  end

  // ********************
  // state registers
  // ********************
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= S_FETCH;
    end else begin
      st_q <= st_d;
    end
  end

  // fetch path, pc advances past every byte taken
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_q <= PC_RESET;
      op_q <= OP_NOP;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
    end else begin
      if (st_q == S_FETCH) begin
        op_q <= mem_rdata;
        pc_q <= pc_q + 16'h0001;
      end
      if (st_q == S_OP1 && nbytes != 2'd1) begin
        b2_q <= mem_rdata;
        pc_q <= pc_q + 16'h0001;
      end
      if (st_q == S_OP2) begin
        b3_q <= mem_rdata;
        pc_q <= pc_q + 16'h0001;
      end
      // RQ18: only OP_BRANCH_ALWAYS loads the target; branch_never and the other branches leave pc alone
      if (st_q == S_EXEC && mode == MODE_RELATIVE && op_q == OP_BRANCH_ALWAYS) begin
        pc_q <= ea;
      end
    end
  end

  // RQ5: temporary address, index untouched
  always_ff @(posedge mclk) begin
    if (srst) begin
      tmp_q <= 16'h0000;
      hi_q  <= 8'h00;
    end else begin
      if (st_q == S_EXEC) begin
        tmp_q <= ea;
      end
      if (st_q == S_OP1 || st_q == S_MEM1) begin
        hi_q <= mem_rdata;
      end
    end
  end

  // multiply stall counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_q <= 4'h0;
    end else if (st_q == S_EXEC) begin
      // RQ15: fetch, idle slot, execute and the final wait cycle make four
      wait_q <= (op_q == OP_MUL) ? MUL_CYCLES - 4'h4 : 4'h0;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  // ********************
  // execute
  // ********************
  logic word_done;
  assign word_done = (st_q == S_MEM2 && operand_mem && !is_std) ||
                     (st_q == S_EXEC && is_word_op && mode == MODE_IMMED);
  always_ff @(posedge mclk) begin
    if (srst) begin
      a_q  <= 8'h00;
      b_q  <= 8'h00;
      x_q  <= X_RESET;
      sp_q <= SP_RESET;
      cc_q <= CC_RESET;
    end else begin
      if (st_q == S_EXEC) begin
        case (op_q)
          // RQ8: flags untouched
          OP_INDEX_PLUS_B: x_q <= index_plus_b;
          // RQ15: RQ22: carry from b bit 7
          OP_MUL: begin
            a_q     <= prod[15:8];
            b_q     <= prod[7:0];
            cc_q[0] <= prod[7];
          end
          // RQ11: zero in, msb to carry
          OP_SHL_DOUBLE: begin
            {a_q, b_q} <= {dbl[14:0], 1'b0};
            cc_q[3:0]  <= {dbl[14], dbl[14:0] == 15'h0000, dbl[15] ^ dbl[14], dbl[15]};
          end
          // RQ12: zero in, lsb to carry
          OP_SHR_DOUBLE: begin
            {a_q, b_q} <= {1'b0, dbl[15:1]};
            cc_q[3:0]  <= {1'b0, dbl[15:1] == 15'h0000, dbl[0], dbl[0]};
          end
          // RQ20: bcd adjust of a
          OP_DECIMAL_ADJUST: begin
            a_q       <= daa_a;
            cc_q[3:0] <= {daa_a[7], daa_a == 8'h00, cc_q[1], daa_c};
          end
          default: ;
        endcase
      end
      // RQ17: pop high byte then low
      if (op_q == OP_POP_INDEX && st_q == S_MEM1) begin
        x_q[15:8] <= mem_rdata;
        sp_q      <= sp_q + 16'h0001;
      end
      if (op_q == OP_POP_INDEX && st_q == S_MEM2) begin
        x_q[7:0] <= mem_rdata;
        sp_q     <= sp_q + 16'h0001;
      end
      // RQ16: one decrement per byte
      if (op_q == OP_PUSH_INDEX && (st_q == S_MEM1 || st_q == S_MEM2)) begin
        sp_q <= sp_q - 16'h0001;
      end
      if (word_done) begin
        // RQ13: load a from m, b from m+1
        if (is_ldd) begin
          {a_q, b_q} <= opnd;
          cc_q[3:1]  <= {opnd[15], opnd == 16'h0000, 1'b0};
        // RQ9: RQ10: sum or difference back to double accumulator
        end else if (is_sum_double_accum || is_subtract_double) begin
          {a_q, b_q} <= alu_y;
          cc_q[3:0]  <= alu_f;
        // RQ19: flags only
        end else if (is_cpx) begin
          cc_q[3:0] <= alu_f;
        end
      end
    end
  end

  // visible state
  assign acc_a      = a_q;
  assign acc_b      = b_q;
  assign index_reg  = x_q;
  assign stack_ptr  = sp_q;
  assign prog_ctr   = pc_q;
  assign cond_codes = cc_q;
  assign instr_done = st_d == S_FETCH && st_q != S_FETCH;

  // ********************
  // checks
  // ********************
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_push_sp_net: assert property (st_q == S_EXEC && op_q == OP_PUSH_INDEX |-> ##3 sp_q == $past(sp_q, 3) - 16'h0002) // RQ16
    else $error("push does not lower sp by two");
  a_pop_sp_net: assert property (st_q == S_EXEC && op_q == OP_POP_INDEX |-> ##3 sp_q == $past(sp_q, 3) + 16'h0002) // RQ17
    else $error("pop does not raise sp by two");
  a_mul_result: assert property (st_q == S_EXEC && op_q == OP_MUL |=> {a_q, b_q} == $past(prod) && cc_q[0] == b_q[7]) // RQ15
    else $error("multiply result wrong");
  a_abx_flags: assert property (st_q == S_EXEC && op_q == OP_INDEX_PLUS_B |=> x_q == $past(index_plus_b) && $stable(cc_q)) // RQ8
    else $error("index plus b wrong");
  a_shl_carry: assert property (st_q == S_EXEC && op_q == OP_SHL_DOUBLE |=> cc_q[0] == $past(a_q[7]) && !b_q[0]) // RQ11
    else $error("left shift carry wrong");
  a_shr_carry: assert property (st_q == S_EXEC && op_q == OP_SHR_DOUBLE |=> cc_q[0] == $past(b_q[0]) && !a_q[7]) // RQ12
    else $error("right shift carry wrong");
  a_fetch_pc_step: assert property (st_q == S_FETCH |=> pc_q == $past(pc_q) + 16'h0001) // RQ23
    else $error("pc did not advance on fetch");
  a_brn_no_jump: assert property (st_q == S_EXEC && op_q == OP_BRANCH_NEVER |=> $stable(pc_q) && st_q == S_FETCH) // RQ18
    else $error("branch never changed pc");
  a_std_bytes: assert property (st_q == S_MEM1 && is_std |-> mem_wdata == a_q ##1 mem_wdata == b_q) // RQ14
    else $error("store double byte order wrong");
  a_index_kept: assert property (st_q == S_EXEC && mode == MODE_INDEXED && is_word_op |=> $stable(x_q)) // RQ5
    else $error("index changed by address calc");
  c_mul: cover property (st_q == S_EXEC && op_q == OP_MUL);
  c_push: cover property (st_q == S_MEM2 && op_q == OP_PUSH_INDEX);
  c_sum_double_accum: cover property (word_done && is_sum_double_accum);
  c_indexed: cover property (st_q == S_MEM1 && mode == MODE_INDEXED);
endmodule

// ### data_memory.sv
// Purpose: byte memory on the far side of the cpu bus
// Assumes: zero-wait reads, writes land on the rising edge
// Notes:   an idle data bus shows the inverse of the last byte read
`timescale 1ns/100ps
module data_memory (
  // clock
  input  wire logic        mclk,
  // cpu bus
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h5a;

  // ********************
  // storage
  // ********************
  // empty memory reads as zero bytes
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end
  // released bus toggles, so a byte taken outside a read cannot match by luck
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
  // writes commit on the edge, last read byte is remembered
  // plain always: the bench also preloads this array directly
  always @(posedge mclk) begin
    if (mem_rd) last_q <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule

// ### cpu_addressing_and_double_ops_tb.sv
// Purpose: self-checking bench for the cpu core
// Assumes: zero-wait memory model, one instruction checked at a time
// Notes:   table rows for the arithmetic, hand-written program for the rest
`timescale 1ns/100ps
module cpu_addressing_and_double_ops_tb;
  import cpu_pkg::*;
  // one ordinary case: opcode, start value of a:b, memory word, result, carry
  typedef struct {
    logic [7:0]  op;
    logic [15:0] d0;
    logic [15:0] m;
    logic [15:0] exp;
    logic        exp_c;
  } row_t;
  // clock and reset
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  // bus and visible state
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [15:0] index_reg;
  logic [15:0] stack_ptr;
  logic [15:0] prog_ctr;
  logic [5:0]  cond_codes;
  logic        instr_done;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc;
  row_t        rows[13] = '{
    '{8'hf3, 16'h1234, 16'h0fcc, 16'h2200, 1'b0},
    '{8'hf3, 16'hffff, 16'h0001, 16'h0000, 1'b1},
    '{8'hb3, 16'h1000, 16'h0001, 16'h0fff, 1'b0},
    '{8'hb3, 16'h0000, 16'h0001, 16'hffff, 1'b1},
    '{8'h83, 16'h1000, 16'h0202, 16'h0dfe, 1'b0},
    '{8'h05, 16'h8001, 16'h0000, 16'h0002, 1'b1},
    '{8'h05, 16'h4000, 16'h0000, 16'h8000, 1'b0},
    '{8'h04, 16'h8001, 16'h0000, 16'h4000, 1'b1},
    '{8'h04, 16'h0002, 16'h0000, 16'h0001, 1'b0},
    '{8'h3d, 16'hffff, 16'h0000, 16'hfe01, 1'b0},
    '{8'h3d, 16'h1008, 16'h0000, 16'h0080, 1'b1},
    '{8'h19, 16'h3c00, 16'h0000, 16'h4200, 1'b0},
    '{8'h19, 16'ha577, 16'h0000, 16'h0577, 1'b1}
  };

  // ********************
  // clock, design and memory
  // ********************
  always #4 mclk = ~mclk;

  cpu_core i_dut (
    .mclk       (mclk),
    .srst       (srst),
    .mem_addr   (mem_addr),
    .mem_rd     (mem_rd),
    .mem_wr     (mem_wr),
    .mem_wdata  (mem_wdata),
    .mem_rdata  (mem_rdata),
    .acc_a      (acc_a),
    .acc_b      (acc_b),
    .index_reg  (index_reg),
    .stack_ptr  (stack_ptr),
    .prog_ctr   (prog_ctr),
    .cond_codes (cond_codes),
    .instr_done (instr_done)
  );

  data_memory i_mem (
    .mclk      (mclk),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );

  // ********************
  // helpers
  // ********************
  // compare with case equality so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic poke(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[k]) begin
      i_mem.mem[a + 16'(k)] = b[k];
    end
  endtask

  function automatic logic [15:0] peek(input logic [15:0] a);
    return {8'h00, i_mem.mem[a]};
  endfunction

  // hold reset 12 cycles, check the reset state, release at a falling edge
  task automatic do_reset;
    srst = 1'b1;
    repeat (12) @(negedge mclk);
    check(prog_ctr, PC_RESET, "reset pc");
    check(stack_ptr, SP_RESET, "reset sp");
    check(index_reg, X_RESET, "reset index");
    check({acc_a, acc_b}, 16'h0000, "reset accumulators");
    check(16'(cond_codes), 16'(CC_RESET), "reset flags");
    srst = 1'b0;
  endtask

  // count cycles up to the done pulse; bounded so a hang cannot stall the run
  task automatic run_instr(output int n);
    for (n = 1; n <= 40; n++) begin
      #1;
      if (instr_done === 1'b1) break;
      @(negedge mclk);
    end
    if (n > 40) check(16'h0000, 16'h0001, "no done pulse");
    @(negedge mclk);
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 3000 cycles
  initial begin
    #(20000 * 8);
    fail_count++;
    summarize();
  end

  // ********************
  // scenarios
  // ********************
  initial begin
    // table: load a:b by extended word load, then the operation under test
    foreach (rows[i]) begin
      poke(16'h0000, '{8'hfc, 8'h02, 8'h00, rows[i].op, 8'h02, 8'h02});
      poke(16'h0200, '{rows[i].d0[15:8], rows[i].d0[7:0], rows[i].m[15:8], rows[i].m[7:0]});
      do_reset();
      run_instr(cyc);
      run_instr(cyc);
      check({acc_a, acc_b}, rows[i].exp, "double result");
      check(16'(cond_codes[0]), 16'(rows[i].exp_c), "carry");
      check(prog_ctr, (rows[i].op[7]) ? 16'h0006 : 16'h0004, "pc step");
      if (rows[i].op == OP_MUL) check(16'(cyc), 16'(MUL_CYCLES), "multiply cycles");
    end
    // hand program: pop, index add, indexed load with carry, push, branches
    poke(16'h0000, '{8'hfc, 8'h02, 8'h00, 8'h38, 8'h3a, 8'hec, 8'hf0, 8'h3c, 8'h21, 8'h05, 8'h20, 8'h03});
    poke(16'h000f, '{8'hdd, 8'h40, 8'hbc, 8'h02, 8'h04, 8'h38, 8'h20, 8'hfe});
    poke(16'h0200, '{8'h00, 8'hf0, 8'h00, 8'h00, 8'h13, 8'h24});
    poke(16'h0100, '{8'h12, 8'h34});
    poke(16'h1414, '{8'h80, 8'h00});
    poke(16'h0040, '{8'hee, 8'hee});
    do_reset();
    run_instr(cyc);
    check({acc_a, acc_b}, 16'h00f0, "load a:b");
    check(16'(cond_codes), 16'h0010, "load flags");
    run_instr(cyc);
    check(index_reg, 16'h1234, "pop index");
    check(stack_ptr, 16'h0101, "pop sp");
    run_instr(cyc);
    check(index_reg, 16'h1324, "index plus b");
    check(16'(cond_codes), 16'h0010, "flags kept");
    check(prog_ctr, 16'h0005, "one-byte step");
    run_instr(cyc);
    check({acc_a, acc_b}, 16'h8000, "indexed load");
    check(index_reg, 16'h1324, "index kept");
    check(16'(cond_codes), 16'h0018, "negative load");
    check(prog_ctr, 16'h0007, "indexed length");
    run_instr(cyc);
    check(peek(16'h0101), 16'h0024, "push low");
    check(peek(16'h0100), 16'h0013, "push high");
    check(stack_ptr, 16'h00ff, "push sp");
    run_instr(cyc);
    check(16'(cyc), 16'(BRN_CYCLES), "branch never cycles");
    check(prog_ctr, 16'h000a, "branch never pc");
    run_instr(cyc);
    check(prog_ctr, 16'h000f, "forward branch");
    run_instr(cyc);
    check(peek(16'h0040), 16'h0080, "store high");
    check(peek(16'h0041), 16'h0000, "store low");
    check({acc_a, acc_b}, 16'h8000, "store keeps a:b");
    check(prog_ctr, 16'h0011, "direct length");
    run_instr(cyc);
    check(16'(cond_codes), 16'h0014, "compare equal");
    check(prog_ctr, 16'h0014, "extended length");
    run_instr(cyc);
    check(index_reg, 16'h1324, "push pop round trip");
    check(stack_ptr, 16'h0101, "pop sp again");
    run_instr(cyc);
    check(prog_ctr, 16'h0015, "backward branch");
    summarize();
  end
endmodule
